// File: rtl/ckgen_params.svh
// Purpose: constants of the clock generator configuration bank
// Assumes: included by bare name from every design module file
// Notes:   definitions only
`ifndef CKGEN_PARAMS_SVH
`define CKGEN_PARAMS_SVH

// ----------------------------------------
// register offsets and layout
// ----------------------------------------
`define CKGEN_NUM_REGS       5
`define CKGEN_OFS_FREQ_LOCK  7'h00
`define CKGEN_OFS_BUS_EN     7'h01
`define CKGEN_OFS_CPU_REF    7'h02
`define CKGEN_OFS_FREE_DRV   7'h03
`define CKGEN_OFS_STRAP_SPR  7'h04
`define CKGEN_BLK_COUNT      8'h05
`define CKGEN_CMD_BLOCK      8'h00
`define CKGEN_CMD_BYTE_BIT   7

// ----------------------------------------
// field positions
// ----------------------------------------
`define CKGEN_B0_WE          0
`define CKGEN_B0_WD          7
`define CKGEN_B0_FS_LSB      1
`define CKGEN_B2_CPU1_RUN    7
`define CKGEN_B2_CPU0_RUN    6
`define CKGEN_B3_BUS_DRV     7
`define CKGEN_B3_LINK_DRV    6
`define CKGEN_B3_FREE_LSB    3
`define CKGEN_B4_FLOP_STRAP  6
`define CKGEN_B4_SPREAD      4

// ----------------------------------------
// reset values and host-writable masks
// ----------------------------------------
`define CKGEN_B0_RST         8'h20
`define CKGEN_B1_RST         8'hFF
`define CKGEN_B2_RST         8'hFE
`define CKGEN_B3_RST         8'h07
`define CKGEN_B4_RST         8'h90
`define CKGEN_B0_MASK        8'h7E
`define CKGEN_B1_MASK        8'hFF
`define CKGEN_B2_MASK        8'hFF
`define CKGEN_B3_MASK        8'hFF
`define CKGEN_B4_MASK        8'hB0
`define CKGEN_NUM_SE         18

`endif

// File: rtl/ckgen_pkg.sv
// Purpose: types of the clock generator configuration bank
// Assumes: constants live in ckgen_params.svh
// Notes:   one state struct per module
package ckgen_pkg;

    // ----------------------------------------
    // transaction phase
    // ----------------------------------------
    typedef enum logic [1:0] {
        CKGEN_IDLE,
        CKGEN_BYTE_ACC,
        CKGEN_BLK_COUNT,
        CKGEN_BLK_DATA
    } ckgen_xfer_type;

    // ----------------------------------------
    // state records
    // ----------------------------------------
    typedef struct packed {
        ckgen_xfer_type   xfer;
        logic [6:0]       ptr;
        logic             unlock;
        logic [4:0][7:0]  regs;
        logic [7:0]       rd_data;
        logic             rd_valid;
    } ckgen_core_type;

    typedef struct packed {
        logic        en_hold;
        logic        out;
        logic        out_b;
    } ckgen_gate_type;

    typedef struct packed {
        logic        done;
        logic        cap;
        logic [3:0]  fs;
        logic        flop;
    } ckgen_strap_type;

endpackage : ckgen_pkg

// File: rtl/ckgen_gate.sv
// Purpose: glitch-free enable gate for one clock output
// Assumes: src sampled as a synchronous level
// Notes:   out_b is the complement for differential pairs
`timescale 1ns/100ps
`include "ckgen_params.svh"

module ckgen_gate (
    // clock and reset
    input  wire logic clk_sys,
    input  wire logic rst,
    // source and enable
    input  wire logic src,
    input  wire logic en,
    // gated output
    output logic      out,
    output logic      out_b
);
    ckgen_pkg::ckgen_gate_type st_reg;
    ckgen_pkg::ckgen_gate_type st_next;

    // ----------------------------------------
    // gate
    // ----------------------------------------
    // enable only moves while the source is low, so no runt pulse
    always_comb begin
        st_next = st_reg;
        if (!src) begin
            st_next.en_hold = en;
        end
        st_next.out   = src & st_next.en_hold;
        st_next.out_b = ~(src & st_next.en_hold);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_reg <= '{en_hold: 1'b1, out: 1'b0, out_b: 1'b1};
        end else begin
            st_reg <= st_next;
        end
    end

    assign out   = st_reg.out;
    assign out_b = st_reg.out_b;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_off_stays_low: assert property (@(posedge clk_sys) disable iff (rst)
        (!en && !src) ##1 !en |=> !out)
        else $error("gated output rose while disabled");

endmodule : ckgen_gate

// File: rtl/ckgen_strap.sv
// Purpose: capture of strap pins after reset release
// Assumes: straps are stable around reset release
// Notes:   cap pulses once, one edge after release
`timescale 1ns/100ps
`include "ckgen_params.svh"

module ckgen_strap (
    // clock and reset
    input  wire logic       clk_sys,
    input  wire logic       rst,
    // strap pins
    input  wire logic [3:0] fs_pins,
    input  wire logic       flop_pin,
    // latched values
    output logic            cap,
    output logic [3:0]      fs_latched,
    output logic            flop_latched
);
    ckgen_pkg::ckgen_strap_type st_reg;
    ckgen_pkg::ckgen_strap_type st_next;

    // ----------------------------------------
    // capture
    // ----------------------------------------
    // a reset must only load constants, so pins are taken after release
    always_comb begin
        st_next     = st_reg;
        st_next.cap = 1'b0;
        if (!st_reg.done) begin
            st_next.done = 1'b1;
            st_next.cap  = 1'b1;
            st_next.fs   = fs_pins;
            st_next.flop = flop_pin;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign cap          = st_reg.cap;
    assign fs_latched   = st_reg.fs;
    assign flop_latched = st_reg.flop;

endmodule : ckgen_strap

// File: rtl/ckgen_regs.sv
// Purpose: configuration bank of the clock generator, serial side
// Assumes: serial framing decoded outside; strobes are one-cycle pulses
// Notes:   all outputs registered
//
// Behaviour
// - write-enable bit 0 unlocks, resets zero
// - writing zero relocks all but write-enable
// - lock change applies from next command
// - locked writes complete but change only byte 0 bits 0 and 7
// - bit 7 after enable disables until reset
// - disabled device still accepts, changes nothing
// - byte 0 bits 4:1 frequency select, strapped
// - enable bits gate their outputs, reset one
// - byte 2 bits 7:6 stop cpu pairs
// - byte 3 bits 5:3 free-run select
// - byte 3 bits 7:6 drive strengths
// - byte 4 reports latched straps
// - byte 4 bit 4 spread enable
// - top command bit selects byte access
// - zero command selects block access
`timescale 1ns/100ps
`include "ckgen_params.svh"

module ckgen_regs #(
    parameter int NUM_SE = `CKGEN_NUM_SE
) (
    // clock and reset
    input  wire logic              clk_sys,
    input  wire logic              rst,
    // serial transaction port
    input  wire logic              cmd_valid,
    input  wire logic [7:0]        cmd_code,
    input  wire logic              wr_valid,
    input  wire logic [7:0]        wr_data,
    input  wire logic              rd_req,
    input  wire logic              xfer_end,
    output logic      [7:0]        rd_data,
    output logic                   rd_valid,
    // strap pins
    input  wire logic              freq_select_bit3,
    input  wire logic              freq_select_bit2,
    input  wire logic              freq_select_bit1,
    input  wire logic              freq_select_bit0,
    input  wire logic              floppy_freq_strap,
    // clock sources and power management
    input  wire logic [NUM_SE-1:0] se_src,
    input  wire logic [1:0]        cpu_src,
    input  wire logic              bus_clk_stop_req,
    // gated clocks
    output logic      [NUM_SE-1:0] clk_out,
    output logic      [1:0]        cpu_true_output,
    output logic      [1:0]        cpu_comp_output,
    // configuration levels
    output logic      [3:0]        freq_sel,
    output logic                   spread_enable,
    output logic                   bus_clock_drive_strength,
    output logic                   link_drive_strength
);
    ckgen_pkg::ckgen_core_type st_reg;
    ckgen_pkg::ckgen_core_type st_next;
    logic                      strap_cap;
    logic [3:0]                strap_fs;
    logic                      strap_flop;
    logic [NUM_SE-1:0]         se_en;
    logic [7:0]                cur_byte;
    logic [6:0]                wr_idx;
    logic                      wr_hit;

    // ----------------------------------------
    // elaboration check
    // ----------------------------------------
    if (NUM_SE != `CKGEN_NUM_SE) begin : g_bad_num_se
        $error("NUM_SE must match the enable bit count");
    end

    // ----------------------------------------
    // strap capture
    // ----------------------------------------
    ckgen_strap u_strap (
        .clk_sys      (clk_sys),
        .rst          (rst),
        .fs_pins      ({freq_select_bit3, freq_select_bit2,
                        freq_select_bit1, freq_select_bit0}),
        .flop_pin     (floppy_freq_strap),
        .cap          (strap_cap),
        .fs_latched   (strap_fs),
        .flop_latched (strap_flop)
    );

    // ----------------------------------------
    // write merge
    // ----------------------------------------
    function automatic logic [4:0][7:0] apply_write(
        input logic [4:0][7:0] r,
        input logic [6:0]      idx,
        input logic [7:0]      d,
        input logic            unl
    );
        logic [4:0][7:0] res;
        logic [4:0][7:0] mask;
        res  = r;
        mask = {`CKGEN_B4_MASK, `CKGEN_B3_MASK, `CKGEN_B2_MASK,
                `CKGEN_B1_MASK, `CKGEN_B0_MASK};
        if (!r[0][`CKGEN_B0_WD] && idx < 7'(`CKGEN_NUM_REGS)) begin
            if (idx == `CKGEN_OFS_FREQ_LOCK) begin
                res[0][`CKGEN_B0_WE] = d[`CKGEN_B0_WE];
                if (d[`CKGEN_B0_WD] && r[0][`CKGEN_B0_WE]) begin
                    res[0][`CKGEN_B0_WD] = 1'b1;
                end
            end
            if (unl) begin
                // merge onto res so the lock bits set above survive
                res[idx[2:0]] = (res[idx[2:0]] & ~mask[idx[2:0]])
                              | (d & mask[idx[2:0]]);
            end
        end
        return res;
    endfunction : apply_write

    // ----------------------------------------
    // transaction and register state
    // ----------------------------------------
    always_comb begin
        wr_idx = st_reg.ptr;
        wr_hit = wr_valid && (st_reg.xfer == ckgen_pkg::CKGEN_BYTE_ACC
                           || st_reg.xfer == ckgen_pkg::CKGEN_BLK_DATA);
        if (st_reg.ptr < 7'(`CKGEN_NUM_REGS)) begin
            cur_byte = st_reg.regs[st_reg.ptr[2:0]];
        end else begin
            cur_byte = 8'h00;
        end
    end

    always_comb begin
        st_next          = st_reg;
        st_next.rd_valid = 1'b0;
        if (strap_cap) begin
            st_next.regs[0][4:1] = strap_fs;
            st_next.regs[4][3:0] = strap_fs;
            st_next.regs[4][`CKGEN_B4_FLOP_STRAP] = strap_flop;
        end
        if (cmd_valid) begin
            // lock snapshot per command; a change inside it waits
            st_next.unlock = st_reg.regs[0][`CKGEN_B0_WE]
                           && !st_reg.regs[0][`CKGEN_B0_WD];
            if (cmd_code[`CKGEN_CMD_BYTE_BIT]) begin
                st_next.xfer = ckgen_pkg::CKGEN_BYTE_ACC;
                st_next.ptr  = cmd_code[6:0];
            end else if (cmd_code == `CKGEN_CMD_BLOCK) begin
                st_next.xfer = ckgen_pkg::CKGEN_BLK_COUNT;
                st_next.ptr  = 7'h00;
            end else begin
                st_next.xfer = ckgen_pkg::CKGEN_IDLE;
            end
        end else if (xfer_end) begin
            st_next.xfer = ckgen_pkg::CKGEN_IDLE;
        end else begin
            case (st_reg.xfer)
                ckgen_pkg::CKGEN_IDLE: begin
                    if (rd_req) begin
                        st_next.rd_valid = 1'b1;
                        st_next.rd_data  = 8'h00;
                    end
                end
                ckgen_pkg::CKGEN_BYTE_ACC: begin
                    if (wr_valid) begin
                        st_next.regs = apply_write(st_next.regs, wr_idx, wr_data,
                                                   st_reg.unlock);
                    end else if (rd_req) begin
                        st_next.rd_valid = 1'b1;
                        st_next.rd_data  = cur_byte;
                    end
                end
                ckgen_pkg::CKGEN_BLK_COUNT: begin
                    // the count byte is taken but not used as a limit
                    if (wr_valid || rd_req) begin
                        st_next.xfer = ckgen_pkg::CKGEN_BLK_DATA;
                    end
                    if (rd_req) begin
                        st_next.rd_valid = 1'b1;
                        st_next.rd_data  = `CKGEN_BLK_COUNT;
                    end
                end
                ckgen_pkg::CKGEN_BLK_DATA: begin
                    if (wr_valid) begin
                        st_next.regs = apply_write(st_next.regs, wr_idx, wr_data,
                                                   st_reg.unlock);
                    end else if (rd_req) begin
                        st_next.rd_valid = 1'b1;
                        st_next.rd_data  = cur_byte;
                    end
                    if ((wr_valid || rd_req) && st_reg.ptr != 7'h7F) begin
                        st_next.ptr = st_reg.ptr + 7'h01;
                    end
                end
                default: begin
                    st_next.xfer = ckgen_pkg::CKGEN_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            st_reg.xfer     <= ckgen_pkg::CKGEN_IDLE;
            st_reg.ptr      <= 7'h00;
            st_reg.unlock   <= 1'b0;
            st_reg.regs     <= {`CKGEN_B4_RST, `CKGEN_B3_RST, `CKGEN_B2_RST,
                                `CKGEN_B1_RST, `CKGEN_B0_RST};
            st_reg.rd_data  <= 8'h00;
            st_reg.rd_valid <= 1'b0;
        end else begin
            st_reg <= st_next;
        end
    end

    // ----------------------------------------
    // output enables
    // ----------------------------------------
    // bus clocks 5..3 sit at indices 6..4; stop request spares free-runners
    always_comb begin
        se_en = {st_reg.regs[4][7], st_reg.regs[3][2:0], st_reg.regs[2][5:1],
                 st_reg.regs[1], st_reg.regs[0][5]};
        se_en[6:4] = se_en[6:4]
                   & ~({3{bus_clk_stop_req}} & ~st_reg.regs[3][5:3]);
    end

    for (genvar i = 0; i < NUM_SE; i++) begin : g_se
        ckgen_gate u_gate (
            .clk_sys (clk_sys),
            .rst     (rst),
            .src     (se_src[i]),
            .en      (se_en[i]),
            .out     (clk_out[i]),
            .out_b   ()
        );
    end

    for (genvar j = 0; j < 2; j++) begin : g_cpu
        ckgen_gate u_gate (
            .clk_sys (clk_sys),
            .rst     (rst),
            .src     (cpu_src[j]),
            .en      (st_reg.regs[2][`CKGEN_B2_CPU0_RUN + j]),
            .out     (cpu_true_output[j]),
            .out_b   (cpu_comp_output[j])
        );
    end

    assign rd_data                  = st_reg.rd_data;
    assign rd_valid                 = st_reg.rd_valid;
    assign freq_sel                 = st_reg.regs[0][4:1];
    assign spread_enable            = st_reg.regs[4][`CKGEN_B4_SPREAD];
    assign bus_clock_drive_strength = st_reg.regs[3][`CKGEN_B3_BUS_DRV];
    assign link_drive_strength      = st_reg.regs[3][`CKGEN_B3_LINK_DRV];

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_reset_values: assert property ($fell(rst) |->
        !st_reg.regs[0][0] && st_reg.regs[3][5:3] == 3'h0 && !st_reg.regs[3][7]
        && !st_reg.regs[3][6] && st_reg.regs[4][4] && st_reg.regs[1] == 8'hFF)
        else $error("register reset values wrong");

    chk_unlock_snap: assert property (cmd_valid |=>
        st_reg.unlock == ($past(st_reg.regs[0][0]) && !$past(st_reg.regs[0][7])))
        else $error("lock snapshot not taken at command");

    chk_locked_hold: assert property ((!st_reg.unlock && !strap_cap) |=>
        $stable(st_reg.regs[3:1]) && $stable(st_reg.regs[4][7:4]))
        else $error("locked bank changed");

    chk_wd_frozen: assert property ((st_reg.regs[0][7] && !strap_cap) |=>
        $stable(st_reg.regs))
        else $error("write-disabled bank changed");

    chk_we_write: assert property ((wr_hit && wr_idx == 7'h00 && !st_reg.regs[0][7]
        && !cmd_valid && !xfer_end) |=> st_reg.regs[0][0] == $past(wr_data[0]))
        else $error("write-enable bit not written");

    chk_wd_set: assert property ((wr_hit && wr_idx == 7'h00 && wr_data[7]
        && st_reg.regs[0][0] && !cmd_valid && !xfer_end) |=> st_reg.regs[0][7])
        else $error("write-disable not set");

    chk_strap_load: assert property (strap_cap |=>
        st_reg.regs[4][3:0] == $past(strap_fs) && freq_sel == $past(strap_fs))
        else $error("straps not loaded");

    chk_byte_read: assert property ((rd_req && !wr_valid && !cmd_valid && !xfer_end
        && st_reg.xfer == ckgen_pkg::CKGEN_BYTE_ACC) |=>
        rd_valid && rd_data == $past(cur_byte))
        else $error("byte read data wrong");

    chk_blk_count: assert property ((rd_req && !cmd_valid && !xfer_end
        && st_reg.xfer == ckgen_pkg::CKGEN_BLK_COUNT) |=>
        rd_valid && rd_data == 8'h05)
        else $error("block count byte wrong");

    chk_cpu_stop: assert property ((!st_reg.regs[2][6] && !cpu_src[0]) |=>
        !cpu_true_output[0] && cpu_comp_output[0])
        else $error("stopped pair not low/high");

    cov_block_write: cover property (st_reg.xfer == ckgen_pkg::CKGEN_BLK_DATA
        && wr_valid && st_reg.unlock);
    cov_byte_read: cover property (st_reg.xfer == ckgen_pkg::CKGEN_BYTE_ACC && rd_req);
    cov_wd_set: cover property ($rose(st_reg.regs[0][7]));

endmodule : ckgen_regs

// File: bench/ckgen_host_model.sv
// Purpose: serial host stand-in that launches the transaction strobes
// Assumes: strobes change 1 ns after the rising edge
// Notes:   released byte lines show the inverse of their last value
`timescale 1ns/100ps

module ckgen_host_model (
    // clock
    input  wire logic       clk_sys,
    // transaction strobes
    output logic            cmd_valid,
    output logic [7:0]      cmd_code,
    output logic            wr_valid,
    output logic [7:0]      wr_data,
    output logic            rd_req,
    output logic            xfer_end,
    // read answer
    input  wire logic [7:0] rd_data,
    input  wire logic       rd_valid
);
    initial begin
        cmd_valid = 1'b0;
        cmd_code  = 8'h5A;
        wr_valid  = 1'b0;
        wr_data   = 8'hA5;
        rd_req    = 1'b0;
        xfer_end  = 1'b0;
    end

    task automatic send_cmd(input logic [7:0] code);
        @(posedge clk_sys);
        #1;
        cmd_valid = 1'b1;
        cmd_code  = code;
        @(posedge clk_sys);
        #1;
        cmd_valid = 1'b0;
        cmd_code  = ~code;
    endtask : send_cmd

    task automatic send_byte(input logic [7:0] d);
        @(posedge clk_sys);
        #1;
        wr_valid = 1'b1;
        wr_data  = d;
        @(posedge clk_sys);
        #1;
        wr_valid = 1'b0;
        wr_data  = ~d;
    endtask : send_byte

    task automatic fetch_byte(output logic [7:0] d, output logic v);
        @(posedge clk_sys);
        #1;
        rd_req = 1'b1;
        @(posedge clk_sys);
        #1;
        rd_req = 1'b0;
        d      = rd_data;
        v      = rd_valid;
    endtask : fetch_byte

    task automatic send_stop();
        @(posedge clk_sys);
        #1;
        xfer_end = 1'b1;
        @(posedge clk_sys);
        #1;
        xfer_end = 1'b0;
    endtask : send_stop
endmodule : ckgen_host_model

// File: bench/clock_gen_config_registers_tb.sv
// Purpose: self-checking bench of the configuration bank
// Assumes: straps start at frequency code A and floppy strap 1
// Notes:   stop request dropped once; straps change before a second reset
`timescale 1ns/100ps
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin failures++; \
    $display("ERROR %s expected %0h seen %0h", nm, e, g); end end

module clock_gen_config_registers_tb;
    logic        clk_sys = 1'b0;
    logic        rst     = 1'b1;
    logic [1:0]  src_div = 2'h0;
    logic [3:0]  fs_pins  = 4'hA;
    logic        flop_pin = 1'b1;
    logic        stop_req = 1'b1;
    logic        cmd_valid, wr_valid, rd_req, xfer_end, rd_valid;
    logic [7:0]  cmd_code, wr_data, rd_data;
    logic [17:0] clk_out;
    logic [1:0]  cpu_t, cpu_c;
    logic [3:0]  freq_sel;
    logic        spread, bus_drv, link_drv;
    logic [19:0] all_clk;
    int          failures  = 0;
    int          cmp_count = 0;
    int          cycles    = 0;
    int          n;

    assign all_clk = {cpu_t, clk_out};
    always #5 clk_sys = ~clk_sys;
    // sources toggle every two cycles so the gates see stable lows
    always @(posedge clk_sys) src_div <= #1 src_div + 2'h1;

    ckgen_host_model u_host (.clk_sys(clk_sys), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
        .wr_valid(wr_valid), .wr_data(wr_data), .rd_req(rd_req), .xfer_end(xfer_end),
        .rd_data(rd_data), .rd_valid(rd_valid));

    ckgen_regs u_dut (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid),
        .cmd_code(cmd_code), .wr_valid(wr_valid), .wr_data(wr_data), .rd_req(rd_req),
        .xfer_end(xfer_end), .rd_data(rd_data), .rd_valid(rd_valid),
        .freq_select_bit3(fs_pins[3]), .freq_select_bit2(fs_pins[2]),
        .freq_select_bit1(fs_pins[1]), .freq_select_bit0(fs_pins[0]),
        .floppy_freq_strap(flop_pin), .se_src({18{src_div[1]}}),
        .cpu_src({2{src_div[1]}}), .bus_clk_stop_req(stop_req), .clk_out(clk_out),
        .cpu_true_output(cpu_t), .cpu_comp_output(cpu_c), .freq_sel(freq_sel),
        .spread_enable(spread), .bus_clock_drive_strength(bus_drv),
        .link_drive_strength(link_drv));

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic byte_wr(input logic [6:0] ofs, input logic [7:0] d);
        u_host.send_cmd({1'b1, ofs});
        u_host.send_byte(d);
        u_host.send_stop();
    endtask : byte_wr

    task automatic byte_rd(input logic [6:0] ofs, input logic [7:0] e);
        logic [7:0] d;
        logic       v;
        u_host.send_cmd({1'b1, ofs});
        u_host.fetch_byte(d, v);
        `CHK("read valid", 1'b1, v)
        `CHK("byte read", e, d)
        u_host.send_stop();
    endtask : byte_rd

    task automatic blk_wr(input logic [4:0][7:0] b);
        u_host.send_cmd(8'h00);
        u_host.send_byte(8'h05);
        for (int i = 0; i < 5; i++) u_host.send_byte(b[i]);
        u_host.send_stop();
    endtask : blk_wr

    task automatic blk_chk(input logic [4:0][7:0] e);
        logic [7:0] d;
        logic       v;
        u_host.send_cmd(8'h00);
        u_host.fetch_byte(d, v);
        `CHK("block count", 8'h05, d)
        for (int i = 0; i < 5; i++) begin
            u_host.fetch_byte(d, v);
            `CHK("block byte", e[i], d)
        end
        u_host.send_stop();
    endtask : blk_chk

    // edges of one output over sixteen cycles
    task automatic act(input int idx, output int cnt);
        logic last;
        cnt  = 0;
        last = all_clk[idx];
        repeat (16) begin
            @(posedge clk_sys);
            #1;
            if (all_clk[idx] !== last) cnt++;
            last = all_clk[idx];
        end
    endtask : act

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            results();
        end
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        repeat (2) @(posedge clk_sys);
        blk_chk({8'hDA, 8'h07, 8'hFE, 8'hFF, 8'h34});
        `CHK("freq select", 4'hA, freq_sel)
        `CHK("spread", 1'b1, spread)
        `CHK("drives", 2'b00, {bus_drv, link_drv})
        act(1, n);
        `CHK("bus0 running", 1'b1, n > 0)
        act(6, n);
        `CHK("bus5 stopped", 1'b0, n > 0)
        stop_req = 1'b0;
        act(6, n);
        `CHK("bus5 no stop", 1'b1, n > 0)
        stop_req = 1'b1;
        act(18, n);
        `CHK("cpu0 running", 1'b1, n > 0)
        byte_wr(7'h01, 8'h00);
        byte_rd(7'h01, 8'hFF);
        blk_wr({8'h00, 8'hF8, 8'h3E, 8'hF0, 8'h35});
        blk_chk({8'hDA, 8'h07, 8'hFE, 8'hFF, 8'h35});
        blk_wr({8'h00, 8'hF8, 8'h3E, 8'hF0, 8'h35});
        blk_chk({8'h4A, 8'hF8, 8'h3E, 8'hF0, 8'h35});
        `CHK("spread off", 1'b0, spread)
        `CHK("drives high", 2'b11, {bus_drv, link_drv})
        `CHK("cpu stopped", 4'h3, {cpu_t, cpu_c})
        act(1, n);
        `CHK("bus0 held", 1'b0, n > 0)
        `CHK("bus0 low", 1'b0, clk_out[1])
        act(6, n);
        `CHK("bus5 free run", 1'b1, n > 0)
        act(19, n);
        `CHK("cpu1 stopped", 1'b0, n > 0)
        byte_wr(7'h00, 8'h34);
        byte_wr(7'h01, 8'hFF);
        byte_rd(7'h01, 8'hF0);
        byte_wr(7'h00, 8'h35);
        byte_rd(7'h00, 8'h35);
        byte_wr(7'h00, 8'hB5);
        byte_rd(7'h00, 8'hB5);
        byte_wr(7'h00, 8'h34);
        byte_wr(7'h01, 8'hFF);
        byte_rd(7'h00, 8'hB5);
        byte_rd(7'h01, 8'hF0);
        byte_rd(7'h05, 8'h00);
        // second reset stands in for a power cycle; new straps get latched
        fs_pins  = 4'h5;
        flop_pin = 1'b0;
        rst      = 1'b1;
        repeat (4) @(posedge clk_sys);
        #1;
        rst = 1'b0;
        repeat (2) @(posedge clk_sys);
        blk_chk({8'h95, 8'h07, 8'hFE, 8'hFF, 8'h2A});
        `CHK("freq select 2", 4'h5, freq_sel)
        results();
    end
endmodule : clock_gen_config_registers_tb
